// *** hdl/enc_cfg_pkg.sv ***
// Constants shared by the filter selection and preset configuration block
package enc_cfg_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [6:0] ADDR_BANK_SELECT   = 7'h40;
	localparam logic [6:0] ADDR_MODE_SELECT   = 7'h6a;
	localparam logic [6:0] ADDR_UNLOCK        = 7'h6b;
	localparam logic [6:0] ADDR_FILTER_ACTIVE = 7'h6e;
	localparam logic [6:0] ADDR_FILTER_CMD    = 7'h24;
	localparam logic [6:0] ADDR_FILTER_STAT   = 7'h25;
	localparam logic [6:0] ADDR_PRESET_CMD    = 7'h00;
	localparam logic [6:0] ADDR_PRESET_STAT   = 7'h01;
	localparam logic [6:0] ADDR_ST_LO         = 7'h02;
	localparam logic [6:0] ADDR_ST_HI         = 7'h04;
	localparam logic [6:0] ADDR_MT_LO         = 7'h05;
	localparam logic [6:0] ADDR_MT_HI         = 7'h07;
	localparam logic [6:0] ADDR_HW_SCOPE      = 7'h08;
	// ==========================================================
	// Values
	localparam logic [7:0] UNLOCK_PASSWORD    = 8'h2a;
	localparam logic [7:0] MODE_NORMAL        = 8'h00;
	localparam logic [7:0] MODE_FILTER        = 8'h05;
	localparam logic [7:0] MODE_PRESET        = 8'h07;
	localparam logic [7:0] BANK_FILTER        = 8'h00;
	localparam logic [7:0] BANK_PRESET        = 8'h01;
	localparam logic [7:0] FCMD_ACCESS        = 8'h01;
	localparam logic [7:0] FCMD_SAVE          = 8'h02;
	localparam logic [7:0] FILTER_BALANCED    = 8'h03;
	localparam logic [7:0] FILTER_DYNAMIC     = 8'h04;
	localparam logic [7:0] FSTAT_READY        = 8'h00;
	localparam logic [7:0] FSTAT_SAVE_OK      = 8'h01;
	localparam logic [7:0] FSTAT_WAIT_VALUE   = 8'h02;
	localparam logic [7:0] PCMD_BOTH          = 8'h01;
	localparam logic [7:0] PCMD_EDIT          = 8'h02;
	localparam logic [7:0] PCMD_SAVE          = 8'h03;
	localparam logic [7:0] PCMD_ST            = 8'h04;
	localparam logic [7:0] PCMD_MT            = 8'h05;
	localparam logic [7:0] PSTAT_IDLE         = 8'h00;
	localparam logic [7:0] PSTAT_EDIT         = 8'h01;
	localparam logic [7:0] SCOPE_BOTH         = 8'h01;
	localparam logic [7:0] SCOPE_ST           = 8'h02;
	localparam logic [7:0] SCOPE_MT           = 8'h03;
	localparam logic [23:0] PRESET_DEFAULT    = 24'h000000;
	// ==========================================================
	// Timing
	localparam int CLK_HZ           = 100_000_000;
	localparam int PRESET_HOLD_MS   = 100;
	localparam int PRESET_HOLD_CYC  = (CLK_HZ / 1000) * PRESET_HOLD_MS;
	localparam int RESTART_CYC_DFLT = 16;
endpackage

// *** hdl/encoder_filter_preset_config.sv ***
// Filter selection and preset command logic of the encoder kit
// ==========================================================
`timescale 1ns/1ps
module encoder_filter_preset_config
	import enc_cfg_pkg::*;
#(
	parameter int PRESET_HOLD = PRESET_HOLD_CYC,
	parameter int RESTART_LEN = RESTART_CYC_DFLT
)(
	// Core clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Link side register access, on the link clock
	input  wire logic        linkClk,
	input  wire logic        linkRst,
	input  wire logic        linkWrite,
	input  wire logic        linkRead,
	input  wire logic [6:0]  linkAddr,
	input  wire logic [7:0]  linkWrData,
	output logic             linkBusy,
	output logic             linkRdValid,
	output logic [7:0]       linkRdData,
	// Hardware preset pin
	input  wire logic        presetPin,
	// Position path
	input  wire logic [23:0] sensorSingleturn,
	input  wire logic [23:0] sensorMultiturn,
	output logic [23:0]      positionSingleturn,
	output logic [23:0]      positionMultiturn,
	output logic             positionValid,
	output logic [7:0]       activeFilter,
	output logic             restartActive
);
	import enc_cfg_pkg::*;

	if (PRESET_HOLD < 1 || RESTART_LEN < 1)
		$error("hold and restart counts must be at least one");

	// ==========================================================
	// Link domain: capture one request, toggle across, await answer
	typedef struct packed {
		logic        busy;
		logic        reqToggle;
		logic        isWrite;
		logic [6:0]  addr;
		logic [7:0]  data;
		logic        ack1;
		logic        ack2;
		logic        ackSeen;
		logic        rdValid;
		logic [7:0]  rdData;
	} link_s;

	link_s lnk;
	link_s next_lnk;
	logic  ackToggle;
	logic [7:0] answerData;

	always_comb
	begin
		next_lnk = lnk;
		next_lnk.ack1 = ackToggle;
		next_lnk.ack2 = lnk.ack1;
		next_lnk.rdValid = 1'b0;
		if (!lnk.busy && (linkWrite || linkRead))
		begin
			next_lnk.busy = 1'b1;
			next_lnk.isWrite = linkWrite;
			next_lnk.addr = linkAddr;
			next_lnk.data = linkWrData;
			next_lnk.reqToggle = ~lnk.reqToggle;
		end
		else if (lnk.busy && (lnk.ack2 != lnk.ackSeen))
		begin
			// Answer data is stable in the core while the ack toggle settles
			next_lnk.busy = 1'b0;
			next_lnk.ackSeen = lnk.ack2;
			next_lnk.rdValid = ~lnk.isWrite;
			next_lnk.rdData = answerData;
		end
	end

	always_ff @(posedge linkClk)
	begin
		if (linkRst)
			lnk <= '0;
		else
			lnk <= next_lnk;
	end

	assign linkBusy = lnk.busy;
	assign linkRdValid = lnk.rdValid;
	assign linkRdData = lnk.rdData;

	// ==========================================================
	// Core domain state
	typedef enum logic [2:0] {
		F_IDLE, F_WAIT_VALUE, F_SAVE_OK
	} fseq_e;

	typedef struct packed {
		logic        req1;
		logic        req2;
		logic        reqSeen;
		logic        ackToggle;
		logic [7:0]  answer;
		logic        unlocked;
		logic [7:0]  mode;
		logic [7:0]  bank;
		fseq_e       fseq;
		logic [7:0]  filterPending;
		logic [7:0]  filterSaved;
		logic        presetEdit;
		logic [23:0] stPreset;
		logic [23:0] mtPreset;
		logic [7:0]  hwScope;
		logic [23:0] stOffset;
		logic [23:0] mtOffset;
		logic [23:0] posSt;
		logic [23:0] posMt;
		logic        pin1;
		logic        pin2;
		logic [31:0] holdCount;
		logic        pinSpent;
		logic [31:0] restartCount;
	} core_s;

	core_s st;
	core_s next_st;

	// Placing byte n of a 24-bit little-endian value
	function automatic logic [23:0] put_byte(input logic [23:0] word,
		input logic [1:0] idx, input logic [7:0] b);
		logic [23:0] w;
		w = word;
		w[idx*8 +: 8] = b;
		return w;
	endfunction

	// Offset that makes the reported position equal the preset value
	function automatic logic [23:0] offset_for(input logic [23:0] target,
		input logic [23:0] raw);
		return target - raw;
	endfunction

	logic        reqNew;
	logic        wr;
	logic [6:0]  a;
	logic [7:0]  d;
	logic        applySt;
	logic        applyMt;
	logic        doRestart;

	assign ackToggle = st.ackToggle;
	assign answerData = st.answer;

	always_comb
	begin
		next_st = st;
		applySt = 1'b0;
		applyMt = 1'b0;
		doRestart = 1'b0;
		next_st.req1 = lnk.reqToggle;
		next_st.req2 = st.req1;
		next_st.pin1 = presetPin;
		next_st.pin2 = st.pin1;
		reqNew = st.req2 != st.reqSeen;
		// Request fields were frozen by the link side on the same edge that moved the toggle
		wr = lnk.isWrite;
		a = lnk.addr;
		d = lnk.data;
		if (st.restartCount != '0)
			next_st.restartCount = st.restartCount - 32'd1;
		if (reqNew && st.restartCount == '0)
		begin
			next_st.reqSeen = st.req2;
			next_st.ackToggle = ~st.ackToggle;
			next_st.answer = 8'h00;
			if (wr)
			begin
				if (a == ADDR_UNLOCK)
					next_st.unlocked = (d == UNLOCK_PASSWORD);
				else if (a == ADDR_MODE_SELECT
					&& (st.unlocked || d == MODE_NORMAL))
				begin
					next_st.mode = d;
					next_st.unlocked = 1'b0;
					next_st.fseq = F_IDLE;
					next_st.presetEdit = 1'b0;
				end
				else if (a == ADDR_BANK_SELECT)
					next_st.bank = d;
				else if (st.mode == MODE_FILTER && st.bank == BANK_FILTER
					&& a == ADDR_FILTER_CMD)
				begin
					case (st.fseq)
						F_IDLE:
							if (d == FCMD_ACCESS)
								next_st.fseq = F_WAIT_VALUE;
						F_WAIT_VALUE:
							if (d == FILTER_BALANCED || d == FILTER_DYNAMIC)
							begin
								next_st.filterPending = d;
								next_st.fseq = F_SAVE_OK;
							end
						F_SAVE_OK:
							if (d == FCMD_SAVE)
							begin
								next_st.filterSaved = st.filterPending;
								doRestart = 1'b1;
							end
						default:
							next_st.fseq = F_IDLE;
					endcase
				end
				else if (st.mode == MODE_PRESET && st.bank == BANK_PRESET)
				begin
					if (a == ADDR_PRESET_CMD)
					begin
						case (d)
							PCMD_EDIT:
								next_st.presetEdit = 1'b1;
							PCMD_SAVE:
								if (st.presetEdit)
									doRestart = 1'b1;
							PCMD_BOTH:
							begin
								applySt = 1'b1;
								applyMt = 1'b1;
								doRestart = 1'b1;
							end
							PCMD_ST:
							begin
								applySt = 1'b1;
								doRestart = 1'b1;
							end
							PCMD_MT:
							begin
								applyMt = 1'b1;
								doRestart = 1'b1;
							end
							default:
								next_st.presetEdit = st.presetEdit;
						endcase
					end
					else if (st.presetEdit && a >= ADDR_ST_LO && a <= ADDR_ST_HI)
						next_st.stPreset = put_byte(st.stPreset, 2'(a - ADDR_ST_LO), d);
					else if (st.presetEdit && a >= ADDR_MT_LO && a <= ADDR_MT_HI)
						next_st.mtPreset = put_byte(st.mtPreset, 2'(a - ADDR_MT_LO), d);
					else if (st.presetEdit && a == ADDR_HW_SCOPE
						&& (d == SCOPE_BOTH || d == SCOPE_ST || d == SCOPE_MT))
						next_st.hwScope = d;
				end
			end
			else
			begin
				if (a == ADDR_MODE_SELECT)
					next_st.answer = st.mode;
				else if (a == ADDR_BANK_SELECT)
					next_st.answer = st.bank;
				else if (a == ADDR_FILTER_ACTIVE)
					next_st.answer = st.filterSaved;
				else if (st.bank == BANK_FILTER && a == ADDR_FILTER_STAT)
				begin
					case (st.fseq)
						F_WAIT_VALUE: next_st.answer = FSTAT_WAIT_VALUE;
						F_SAVE_OK:    next_st.answer = FSTAT_SAVE_OK;
						default:      next_st.answer = FSTAT_READY;
					endcase
				end
				else if (st.bank == BANK_PRESET)
				begin
					if (a == ADDR_PRESET_STAT)
						next_st.answer = st.presetEdit ? PSTAT_EDIT : PSTAT_IDLE;
					else if (a >= ADDR_ST_LO && a <= ADDR_ST_HI)
						next_st.answer = st.stPreset[2'(a - ADDR_ST_LO)*8 +: 8];
					else if (a >= ADDR_MT_LO && a <= ADDR_MT_HI)
						next_st.answer = st.mtPreset[2'(a - ADDR_MT_LO)*8 +: 8];
					else if (a == ADDR_HW_SCOPE)
						next_st.answer = st.hwScope;
				end
			end
		end
		// Hardware preset: filtered pin, fires once per assertion
		if (!st.pin2)
		begin
			next_st.holdCount = '0;
			next_st.pinSpent = 1'b0;
		end
		else if (!st.pinSpent)
		begin
			if (st.holdCount >= 32'(PRESET_HOLD - 1))
			begin
				next_st.pinSpent = 1'b1;
				applySt = applySt || st.hwScope != SCOPE_MT;
				applyMt = applyMt || st.hwScope != SCOPE_ST;
				doRestart = 1'b1;
			end
			else
				next_st.holdCount = st.holdCount + 32'd1;
		end
		if (applySt)
			next_st.stOffset = offset_for(st.stPreset, sensorSingleturn);
		if (applyMt)
			next_st.mtOffset = offset_for(st.mtPreset, sensorMultiturn);
		// Registered position trails the sensor by one core cycle
		next_st.posSt = sensorSingleturn + next_st.stOffset;
		next_st.posMt = sensorMultiturn + next_st.mtOffset;
		if (doRestart)
		begin
			// Restart leaves configuration mode; the master must unlock again
			next_st.restartCount = 32'(RESTART_LEN);
			next_st.mode = MODE_NORMAL;
			next_st.unlocked = 1'b0;
			next_st.fseq = F_IDLE;
			next_st.presetEdit = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st <= '0;
			st.filterSaved <= FILTER_BALANCED;
			st.hwScope <= SCOPE_BOTH;
			st.stPreset <= PRESET_DEFAULT;
			st.mtPreset <= PRESET_DEFAULT;
		end
		else
			st <= next_st;
	end

	// ==========================================================
	// Outputs
	assign positionSingleturn = st.posSt;
	assign positionMultiturn = st.posMt;
	assign activeFilter = st.filterSaved;
	assign restartActive = st.restartCount != '0;
	assign positionValid = st.restartCount == '0 && st.mode == MODE_NORMAL;
endmodule

// *** tb/encoder_filter_preset_config_asserts.sv ***
// Port-level assertions for the filter and preset configuration block
`timescale 1ns/1ps
module encoder_filter_preset_config_asserts
	import enc_cfg_pkg::*;
#(
	parameter int PRESET_HOLD = 20,
	parameter int RESTART_LEN = 16
)(
	// Clocks, resets and link side
	input wire logic        core_clk, rst, linkClk, linkRst, linkWrite, linkRead,
	input wire logic [6:0]  linkAddr,
	input wire logic [7:0]  linkWrData, linkRdData, activeFilter,
	input wire logic        linkBusy, linkRdValid, presetPin,
	// Position path
	input wire logic [23:0] sensorSingleturn, sensorMultiturn,
	input wire logic [23:0] positionSingleturn, positionMultiturn,
	input wire logic        positionValid, restartActive
);
	// ==========================================================
	// Sequences
	sequence s_restart_run;
		restartActive[*8];
	endsequence
	// ==========================================================
	// Properties
	property p_rdv_pulse;
		@(posedge linkClk) disable iff (linkRst) linkRdValid |=> !linkRdValid;
	endproperty
	a_rdv_pulse: assert property (p_rdv_pulse) else $error("read valid too long");
	property p_busy_take;
		@(posedge linkClk) disable iff (linkRst)
		!linkBusy && (linkWrite || linkRead) |-> ##[1:2] linkBusy;
	endproperty
	a_busy_take: assert property (p_busy_take) else $error("request not taken");
	property p_busy_bound;
		@(posedge linkClk) disable iff (linkRst) $rose(linkBusy) |-> ##[1:60] !linkBusy;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("busy never ends");
	property p_valid_restart;
		@(posedge core_clk) disable iff (rst) restartActive[*2] |-> !positionValid;
	endproperty
	a_valid_restart: assert property (p_valid_restart) else $error("valid in restart");
	property p_restart_len;
		@(posedge core_clk) disable iff (rst)
		$rose(restartActive) |-> s_restart_run ##[1:20] !restartActive;
	endproperty
	a_restart_len: assert property (p_restart_len) else $error("restart length");
	property p_filter_code;
		@(posedge core_clk) disable iff (rst)
		activeFilter == FILTER_BALANCED || activeFilter == FILTER_DYNAMIC;
	endproperty
	a_filter_code: assert property (p_filter_code) else $error("bad filter code");
	property p_reset_pos;
		@(posedge core_clk) disable iff (rst) $fell(rst) |=>
		positionSingleturn == sensorSingleturn && positionMultiturn == sensorMultiturn;
	endproperty
	a_reset_pos: assert property (p_reset_pos) else $error("preset not zero");
	property p_pin_once;
		@(posedge core_clk) disable iff (rst)
		$fell(restartActive) && presetPin |=> (!restartActive)[*8];
	endproperty
	a_pin_once: assert property (p_pin_once) else $error("preset repeated");
endmodule

// *** tb/encoder_filter_preset_config_tb_top.sv ***
// Self-checking bench for the filter and preset configuration block
`timescale 1ns/1ps
module encoder_filter_preset_config_tb_top;
	import enc_cfg_pkg::*;
	logic        core_clk, rst, linkClk, linkRst, linkWrite, linkRead, linkBusy, linkRdValid;
	logic [6:0]  linkAddr;
	logic [7:0]  linkWrData, linkRdData, activeFilter, q;
	logic        presetPin, positionValid, restartActive, sawRestart;
	logic [23:0] sensorSingleturn, sensorMultiturn, positionSingleturn, positionMultiturn;
	logic [23:0] offSt, offMt;
	localparam logic [23:0] PST = 24'h018000;
	localparam logic [23:0] PMT = 24'h000123;
	int          n_mismatch = 0;
	int          total_checks = 0;
	typedef struct {logic [7:0] cmd; logic [23:0] sSt; logic [23:0] sMt;} row_s;
	row_s rows[3] = '{'{PCMD_BOTH, 24'h000100, 24'h000005},
		'{PCMD_ST, 24'h000200, 24'h000009}, '{PCMD_MT, 24'h000300, 24'h00000c}};
	logic [7:0] filt[2] = '{FILTER_DYNAMIC, FILTER_BALANCED};

	encoder_filter_preset_config #(.PRESET_HOLD(20)) encoder_filter_preset_config_inst (
		.core_clk, .rst, .linkClk, .linkRst, .linkWrite, .linkRead, .linkAddr, .linkWrData,
		.linkBusy, .linkRdValid, .linkRdData, .presetPin, .sensorSingleturn,
		.sensorMultiturn, .positionSingleturn, .positionMultiturn, .positionValid,
		.activeFilter, .restartActive);
	link_master_model link_master_model_inst (.linkClk, .linkBusy, .linkRdValid,
		.linkRdData, .linkWrite, .linkRead, .linkAddr, .linkWrData);

	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		linkClk = 0;
		#3.7;
		forever #40 linkClk = ~linkClk;
	end
	always @(posedge core_clk) sawRestart <= sawRestart | restartActive;

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
		link_master_model_inst.xfer(r, a, d, q);
		if (link_master_model_inst.hang)
		begin
			n_mismatch++;
			results();
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		xfer(1'b0, a, d);
	endtask
	task automatic rdc(input string nm, input logic [6:0] a, input logic [7:0] e);
		xfer(1'b1, a, 8'h00);
		chk(nm, {16'h0000, e}, {16'h0000, q});
	endtask
	task automatic enter(input logic [7:0] mode, input logic [7:0] bank);
		wr(ADDR_UNLOCK, UNLOCK_PASSWORD);
		wr(ADDR_MODE_SELECT, mode);
		wr(ADDR_BANK_SELECT, bank);
	endtask
	// Restart can begin before the write returns, so a sticky flag catches it
	task automatic waitRestart;
		int n;
		n = 0;
		while (!(sawRestart && !restartActive) && ++n < 400) @(negedge core_clk);
		@(negedge core_clk);
		sawRestart = 0;
		if (n >= 400)
		begin
			n_mismatch++;
			results();
		end
	endtask
	task automatic chkPos;
		chk("posSt", sensorSingleturn + offSt, positionSingleturn);
		chk("posMt", sensorMultiturn + offMt, positionMultiturn);
	endtask

	initial
	begin
		{rst, linkRst, presetPin, sawRestart, offSt, offMt} = {4'b1100, 48'h0};
		{sensorSingleturn, sensorMultiturn} = {24'h000777, 24'h000040};
		repeat (12) @(negedge core_clk);
		rst = 0;
		repeat (2) @(negedge linkClk);
		linkRst = 0;
		chk("filtRst", FILTER_BALANCED, activeFilter);
		chkPos();
		wr(ADDR_MODE_SELECT, MODE_FILTER);
		wr(ADDR_FILTER_CMD, FCMD_ACCESS);
		chk("validLocked", 24'h000001, positionValid);
		rdc("modeLocked", ADDR_MODE_SELECT, MODE_NORMAL);
		rdc("fstatLocked", ADDR_FILTER_STAT, FSTAT_READY);
		enter(MODE_FILTER, BANK_FILTER);
		rdc("modeCfg", ADDR_MODE_SELECT, MODE_FILTER);
		wr(ADDR_MODE_SELECT, MODE_NORMAL);
		rdc("modeNorm", ADDR_MODE_SELECT, MODE_NORMAL);
		chk("validBack", 24'h000001, positionValid);
		for (int i = 0; i < 2; i++)
		begin
			enter(MODE_FILTER, BANK_FILTER);
			rdc("fstat", ADDR_FILTER_STAT, FSTAT_READY);
			wr(ADDR_FILTER_CMD, FCMD_ACCESS);
			rdc("fstat", ADDR_FILTER_STAT, FSTAT_WAIT_VALUE);
			chk("validCfg", 24'h000000, positionValid);
			wr(ADDR_FILTER_CMD, filt[i]);
			rdc("fstat", ADDR_FILTER_STAT, FSTAT_SAVE_OK);
			wr(ADDR_FILTER_CMD, FCMD_SAVE);
			waitRestart();
			wr(ADDR_MODE_SELECT, MODE_NORMAL);
			rdc("filtReg", ADDR_FILTER_ACTIVE, filt[i]);
			chk("filtOut", {16'h0000, filt[i]}, activeFilter);
			chk("validNorm", 24'h000001, positionValid);
		end
		enter(MODE_PRESET, BANK_PRESET);
		rdc("scope", ADDR_HW_SCOPE, SCOPE_BOTH);
		wr(ADDR_PRESET_CMD, PCMD_EDIT);
		rdc("pstat", ADDR_PRESET_STAT, PSTAT_EDIT);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_ST_LO + 7'(i), PST[8*i+:8]);
			wr(ADDR_MT_LO + 7'(i), PMT[8*i+:8]);
		end
		rdc("stMid", ADDR_ST_LO + 7'h01, 8'h80);
		wr(ADDR_HW_SCOPE, SCOPE_ST);
		wr(ADDR_PRESET_CMD, PCMD_SAVE);
		waitRestart();
		foreach (rows[i])
		begin
			{sensorSingleturn, sensorMultiturn} = {rows[i].sSt, rows[i].sMt};
			enter(MODE_PRESET, BANK_PRESET);
			wr(ADDR_PRESET_CMD, rows[i].cmd);
			waitRestart();
			wr(ADDR_MODE_SELECT, MODE_NORMAL);
			if (rows[i].cmd != PCMD_MT) offSt = PST - rows[i].sSt;
			if (rows[i].cmd != PCMD_ST) offMt = PMT - rows[i].sMt;
			chkPos();
		end
		{sensorSingleturn, sensorMultiturn} = {24'h000777, 24'h000040};
		presetPin = 1;
		repeat (10) @(negedge core_clk);
		presetPin = 0;
		repeat (40) @(negedge core_clk);
		chk("shortPin", 24'h000000, sawRestart);
		presetPin = 1;
		waitRestart();
		repeat (30) @(negedge core_clk);
		presetPin = 0;
		offSt = PST - 24'h000777;
		chkPos();
		results();
	end
endmodule

bind encoder_filter_preset_config encoder_filter_preset_config_asserts #(
	.PRESET_HOLD(PRESET_HOLD), .RESTART_LEN(RESTART_LEN)) chk_inst (
	.core_clk, .rst, .linkClk, .linkRst, .linkWrite, .linkRead, .linkAddr, .linkWrData,
	.linkRdData, .activeFilter, .linkBusy, .linkRdValid, .presetPin, .sensorSingleturn,
	.sensorMultiturn, .positionSingleturn, .positionMultiturn, .positionValid,
	.restartActive);

// *** tb/link_master_model.sv ***
// Serial link master model issuing register reads and writes
`timescale 1ns/1ps
module link_master_model (
	// Link side
	input  wire logic       linkClk,
	input  wire logic       linkBusy,
	input  wire logic       linkRdValid,
	input  wire logic [7:0] linkRdData,
	output logic            linkWrite,
	output logic            linkRead,
	output logic [6:0]      linkAddr,
	output logic [7:0]      linkWrData
);
	logic hang = 0;
	initial
	begin
		linkWrite = 0;
		linkRead = 0;
		linkAddr = 7'h7f;
		linkWrData = 8'hff;
	end
	// Drives on falling edges; busy seen high means the rising edge before took it
	task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(negedge linkClk);
		{linkRead, linkWrite, linkAddr, linkWrData} = {r, !r, a, d};
		do @(negedge linkClk); while (!linkBusy && ++n < 100);
		{linkRead, linkWrite, linkAddr, linkWrData} = {2'b00, ~a, ~d};
		while ((r ? !linkRdValid : linkBusy) && ++n < 100) @(negedge linkClk);
		q = linkRdData;
		hang = n >= 100;
	endtask
endmodule
